// >>> pkg/bcc_consts.svh
// constants of the bcd calendar clock: offsets, fields, resets, limits
`ifndef BCC_CONSTS_SVH
`define BCC_CONSTS_SVH

// bus geometry
`define BCC_ADDR_W 8
`define BCC_WORD_BYTES 8'h04
`define BCC_RESP_OKAY 2'h0
`define BCC_RESP_SLVERR 2'h2

// register byte offsets
`define BCC_OFF_CTRL 8'h40
`define BCC_OFF_TICK 8'h44
`define BCC_OFF_ALMCTL 8'h50
`define BCC_OFF_ALM_BASE 8'h54
`define BCC_OFF_CAL_BASE 8'h70

// field positions
`define BCC_CTRL_WREN 0
`define BCC_CTRL_CLKRST 3
`define BCC_CTRL_W 4
`define BCC_ALM_MASTER 6
`define BCC_ALMCTL_MASK 8'h7F
`define BCC_TICK_EN 7
`define BCC_TICK_CNT_W 7

// reset values
`define BCC_RST_CTRL 4'h0
`define BCC_RST_TICK 8'h00
`define BCC_RST_ALMCTL 8'h00
`define BCC_RST_ZERO 8'h00
`define BCC_RST_ONE 8'h01

// alarm field masks (reserved bits read zero)
`define BCC_MASK_SECMIN 8'h7F
`define BCC_MASK_HRDATE 8'h3F
`define BCC_MASK_MONTH 8'h1F
`define BCC_MASK_YEAR 8'hFF

// time base: crystal edges per 1/128 s and per second
`define BCC_XTAL_HZ 32768
`define BCC_TICK_HZ 128
`define BCC_DIV_W 15
`define BCC_TICK_SPAN (`BCC_XTAL_HZ / `BCC_TICK_HZ)
`define BCC_TICK_WRAP 15'((`BCC_TICK_SPAN) - 1)
`define BCC_SEC_WRAP 15'((`BCC_XTAL_HZ) - 1)

// bcd limits
`define BCC_MAX_SECMIN 8'h59
`define BCC_MAX_HOUR 8'h23
`define BCC_MAX_WDAY 8'h07
`define BCC_MAX_MONTH 8'h12
`define BCC_MAX_YEAR 8'h99
`define BCC_FEB 8'h02
`define BCC_APR 8'h04
`define BCC_JUN 8'h06
`define BCC_SEP 8'h09
`define BCC_NOV 8'h11
`define BCC_LAST_28 8'h28
`define BCC_LAST_29 8'h29
`define BCC_LAST_30 8'h30
`define BCC_LAST_31 8'h31

`endif

// >>> pkg/bcc_pkg.sv
// types of the bcd calendar clock
package bcc_pkg;
    typedef logic [7:0] bcc_bcd_type;
    typedef logic [1:0] bcc_resp_type;
    // calendar field slots, also the counter register order
    typedef enum logic [2:0]
    {
        BCC_F_SEC = 3'h0,
        BCC_F_MIN = 3'h1,
        BCC_F_HOUR = 3'h2,
        BCC_F_DATE = 3'h3,
        BCC_F_WDAY = 3'h4,
        BCC_F_MONTH = 3'h5,
        BCC_F_YEAR = 3'h6
    } bcc_field_type;
    localparam int BCC_NFIELDS = 7;
    localparam int BCC_NALARM = 6;
endpackage

// >>> pkg/bcc_cal_if.sv
// calendar state and next-state between keeper and rollover logic
`timescale 1ns/1ps
interface bcc_cal_if;
    import bcc_pkg::*;
    logic advance;
    bcc_bcd_type cur [BCC_NFIELDS];
    bcc_bcd_type nxt [BCC_NFIELDS];
    modport calc
    (
        input advance,
        input cur,
        output nxt
    );
    modport keeper
    (
        output advance,
        output cur,
        input nxt
    );
endinterface

// >>> src/bcc_cal_next.sv
// rollover and leap-year logic of the bcd calendar
`timescale 1ns/1ps
`include "bcc_consts.svh"
module bcc_cal_next
    import bcc_pkg::*;
(
    bcc_cal_if.calc cal
);
    function automatic bcc_bcd_type bcd_inc(input bcc_bcd_type v);
        bcc_bcd_type r;
        r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
        return r;
    endfunction

    wire [3:0] year_tens = cal.cur[BCC_F_YEAR][7:4];
    wire [3:0] year_units = cal.cur[BCC_F_YEAR][3:0];
    // year 00 divides by four, so it counts as 2000 and is leap
    wire leap = year_tens[0] ? (year_units == 4'h2 || year_units == 4'h6)
        : (year_units == 4'h0 || year_units == 4'h4
        || year_units == 4'h8);
    wire [7:0] month = cal.cur[BCC_F_MONTH];
    wire short_month = (month == `BCC_APR) || (month == `BCC_JUN)
        || (month == `BCC_SEP) || (month == `BCC_NOV);
    wire bcc_bcd_type last_day = (month == `BCC_FEB)
        ? (leap ? `BCC_LAST_29 : `BCC_LAST_28)
        : (short_month ? `BCC_LAST_30 : `BCC_LAST_31);

    bcc_bcd_type max_v [BCC_NFIELDS];
    bcc_bcd_type min_v [BCC_NFIELDS];
    logic carry [BCC_NFIELDS];
    logic roll [BCC_NFIELDS];

    assign max_v[BCC_F_SEC] = `BCC_MAX_SECMIN;
    assign max_v[BCC_F_MIN] = `BCC_MAX_SECMIN;
    assign max_v[BCC_F_HOUR] = `BCC_MAX_HOUR;
    assign max_v[BCC_F_DATE] = last_day;
    assign max_v[BCC_F_WDAY] = `BCC_MAX_WDAY;
    assign max_v[BCC_F_MONTH] = `BCC_MAX_MONTH;
    assign max_v[BCC_F_YEAR] = `BCC_MAX_YEAR;
    assign min_v[BCC_F_SEC] = `BCC_RST_ZERO;
    assign min_v[BCC_F_MIN] = `BCC_RST_ZERO;
    assign min_v[BCC_F_HOUR] = `BCC_RST_ZERO;
    assign min_v[BCC_F_DATE] = `BCC_RST_ONE;
    assign min_v[BCC_F_WDAY] = `BCC_RST_ONE;
    assign min_v[BCC_F_MONTH] = `BCC_RST_ONE;
    assign min_v[BCC_F_YEAR] = `BCC_RST_ZERO;

    // weekday steps with every date step, month follows the date rollover
    assign carry[BCC_F_SEC] = cal.advance;
    assign carry[BCC_F_MIN] = carry[BCC_F_SEC] & roll[BCC_F_SEC];
    assign carry[BCC_F_HOUR] = carry[BCC_F_MIN] & roll[BCC_F_MIN];
    assign carry[BCC_F_DATE] = carry[BCC_F_HOUR] & roll[BCC_F_HOUR];
    assign carry[BCC_F_WDAY] = carry[BCC_F_DATE];
    assign carry[BCC_F_MONTH] = carry[BCC_F_DATE] & roll[BCC_F_DATE];
    assign carry[BCC_F_YEAR] = carry[BCC_F_MONTH] & roll[BCC_F_MONTH];

    // a value beyond its limit after a write also wraps
    genvar i;
    generate
        for (i = 0; i < BCC_NFIELDS; i++)
        begin : g_field
            assign roll[i] = cal.cur[i] >= max_v[i];
            assign cal.nxt[i] = !carry[i] ? cal.cur[i]
                : (roll[i] ? min_v[i] : bcd_inc(cal.cur[i]));
        end
    endgenerate
endmodule

// >>> src/bcc_top.sv
// bcd calendar clock with alarm and tick, axi4-lite register slave
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "bcc_consts.svh"
module bcc_top
    import bcc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic xtal_clk,
    input wire logic main_power_off,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output bcc_resp_type bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output bcc_resp_type rresp,
    output logic rvalid,
    input wire logic rready,
    output logic alarm_irq,
    output logic tick_irq,
    output logic power_wake_request
);
    // pin synchronisers
    logic xtal_s1_q, xtal_s2_q, xtal_s3_q;
    logic poff_s1_q, poff_s2_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            xtal_s1_q <= 1'b0;
            xtal_s2_q <= 1'b0;
            xtal_s3_q <= 1'b0;
            poff_s1_q <= 1'b0;
            poff_s2_q <= 1'b0;
        end
        else if (ce)
        begin
            xtal_s1_q <= xtal_clk;
            xtal_s2_q <= xtal_s1_q;
            xtal_s3_q <= xtal_s2_q;
            poff_s1_q <= main_power_off;
            poff_s2_q <= poff_s1_q;
        end
    end
    wire xtal_rise = xtal_s2_q & ~xtal_s3_q;
    wire powered_off = poff_s2_q;

    // bus write side
    logic aw_have_q, w_have_q, bvalid_q;
    logic [7:0] aw_addr_q;
    logic [7:0] w_byte_q;
    logic w_lane0_q;
    bcc_resp_type bresp_q;
    assign awready = ~aw_have_q & ~bvalid_q;
    assign wready = ~w_have_q & ~bvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    wire do_write = aw_have_q & w_have_q & ~bvalid_q;
    // no bus write reaches the block while main power is off
    wire wr_live = do_write & w_lane0_q & ~powered_off;

    // register state
    logic [`BCC_CTRL_W-1:0] ctrl_q;
    logic [7:0] tick_reg_q;
    logic [`BCC_TICK_CNT_W-1:0] tick_cnt_q;
    logic [7:0] alm_ctl_q;
    bcc_bcd_type alm_q [BCC_NALARM];
    bcc_bcd_type cal_q [BCC_NFIELDS];
    logic [`BCC_DIV_W-1:0] div_q;
    logic adv_q, alarm_irq_q, tick_irq_q, wake_q;

    wire wr_ctrl = wr_live & (aw_addr_q == `BCC_OFF_CTRL);
    wire wr_tick = wr_live & (aw_addr_q == `BCC_OFF_TICK);
    wire wr_almctl = wr_live & (aw_addr_q == `BCC_OFF_ALMCTL);
    wire cal_wr_ok = wr_live & ctrl_q[`BCC_CTRL_WREN];

    // alarm slot to calendar slot and reserved-bit masks
    localparam bcc_field_type ALM_FIELD [BCC_NALARM] = '{BCC_F_SEC,
        BCC_F_MIN, BCC_F_HOUR, BCC_F_DATE, BCC_F_MONTH, BCC_F_YEAR};
    localparam bcc_bcd_type ALM_MASK [BCC_NALARM] = '{`BCC_MASK_SECMIN,
        `BCC_MASK_SECMIN, `BCC_MASK_HRDATE, `BCC_MASK_HRDATE,
        `BCC_MASK_MONTH, `BCC_MASK_YEAR};
    localparam bcc_bcd_type ALM_RST [BCC_NALARM] = '{`BCC_RST_ZERO,
        `BCC_RST_ZERO, `BCC_RST_ZERO, `BCC_RST_ONE, `BCC_RST_ONE,
        `BCC_RST_ZERO};
    localparam bcc_bcd_type CAL_RST [BCC_NFIELDS] = '{`BCC_RST_ZERO,
        `BCC_RST_ZERO, `BCC_RST_ZERO, `BCC_RST_ONE, `BCC_RST_ONE,
        `BCC_RST_ONE, `BCC_RST_ZERO};

    // time base: 1/128 s and 1 s strobes from crystal edges
    wire tick128 = xtal_rise & (div_q[7:0] == 8'(`BCC_TICK_WRAP));
    wire sec_tick = xtal_rise & (div_q == `BCC_SEC_WRAP);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            div_q <= '0;
        else if (ce)
        begin
            if (ctrl_q[`BCC_CTRL_CLKRST])
                div_q <= '0;
            else if (xtal_rise)
                div_q <= div_q + `BCC_DIV_W'(1);
        end
    end

    // calendar counters
    bcc_cal_if cal ();
    bcc_cal_next u_next (
        .cal(cal)
    );
    assign cal.advance = sec_tick;
    logic [BCC_NALARM-1:0] alm_hit_ok;
    genvar i;
    generate
        for (i = 0; i < BCC_NFIELDS; i++)
        begin : g_cal
            wire wr_me = cal_wr_ok & (aw_addr_q
                == `BCC_OFF_CAL_BASE + 8'(i) * `BCC_WORD_BYTES);
            assign cal.cur[i] = cal_q[i];
            // counting goes on whatever the power state
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    cal_q[i] <= CAL_RST[i];
                else if (ce)
                    cal_q[i] <= wr_me ? w_byte_q : cal.nxt[i];
            end
        end
        for (i = 0; i < BCC_NALARM; i++)
        begin : g_alm
            wire wr_me = wr_live & (aw_addr_q
                == `BCC_OFF_ALM_BASE + 8'(i) * `BCC_WORD_BYTES);
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    alm_q[i] <= ALM_RST[i];
                else if (ce && wr_me)
                    alm_q[i] <= w_byte_q & ALM_MASK[i];
            end
            // a disabled field always agrees
            assign alm_hit_ok[i] = ~alm_ctl_q[i]
                | (cal_q[ALM_FIELD[i]] == alm_q[i]);
        end
    endgenerate

    // alarm is judged once per second on the freshly advanced time
    wire alarm_match = adv_q & alm_ctl_q[`BCC_ALM_MASTER]
        & (&alm_hit_ok);
    wire tick_zero = (tick_cnt_q == '0);
    wire tick_fire = tick128 & tick_zero & tick_reg_q[`BCC_TICK_EN];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q <= `BCC_RST_CTRL;
            alm_ctl_q <= `BCC_RST_ALMCTL;
            adv_q <= 1'b0;
            alarm_irq_q <= 1'b0;
            wake_q <= 1'b0;
            tick_irq_q <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_ctrl)
                ctrl_q <= w_byte_q[`BCC_CTRL_W-1:0];
            if (wr_almctl)
                alm_ctl_q <= w_byte_q & `BCC_ALMCTL_MASK;
            adv_q <= sec_tick;
            alarm_irq_q <= alarm_match;
            wake_q <= alarm_match & powered_off;
            tick_irq_q <= tick_fire;
        end
    end
    assign alarm_irq = alarm_irq_q;
    assign power_wake_request = wake_q;
    assign tick_irq = tick_irq_q;

    // tick counter: reload at zero gives n+1 steps of 1/128 s
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tick_reg_q <= `BCC_RST_TICK;
            tick_cnt_q <= '0;
        end
        else if (ce)
        begin
            if (wr_tick)
            begin
                tick_reg_q <= w_byte_q;
                tick_cnt_q <= w_byte_q[`BCC_TICK_CNT_W-1:0];
            end
            else if (tick128)
                tick_cnt_q <= tick_zero
                    ? tick_reg_q[`BCC_TICK_CNT_W-1:0]
                    : tick_cnt_q - `BCC_TICK_CNT_W'(1);
        end
    end

    // write channel capture and response
    logic [BCC_NFIELDS+BCC_NALARM-1:0] g_hit_w;
    wire wr_hit = (aw_addr_q == `BCC_OFF_CTRL)
        | (aw_addr_q == `BCC_OFF_TICK) | (aw_addr_q == `BCC_OFF_ALMCTL)
        | (|g_hit_w);
    generate
        for (i = 0; i < BCC_NFIELDS; i++)
        begin : g_hw_cal
            assign g_hit_w[i] = aw_addr_q
                == `BCC_OFF_CAL_BASE + 8'(i) * `BCC_WORD_BYTES;
        end
        for (i = 0; i < BCC_NALARM; i++)
        begin : g_hw_alm
            assign g_hit_w[BCC_NFIELDS+i] = aw_addr_q
                == `BCC_OFF_ALM_BASE + 8'(i) * `BCC_WORD_BYTES;
        end
    endgenerate
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            aw_addr_q <= '0;
            w_byte_q <= '0;
            w_lane0_q <= 1'b0;
            bresp_q <= `BCC_RESP_OKAY;
        end
        else if (ce)
        begin
            if (awvalid && awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_have_q <= 1'b1;
                w_byte_q <= wdata[7:0];
                w_lane0_q <= wstrb[0];
            end
            if (do_write)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `BCC_RESP_OKAY : `BCC_RESP_SLVERR;
            end
            else if (bvalid_q && bready)
                bvalid_q <= 1'b0;
        end
    end

    // read side: byte in the low lane, upper bits zero
    function automatic logic [8:0] rd_mux(input logic [7:0] a);
        logic [8:0] r;
        r = {1'b0, 8'h00};
        if (a == `BCC_OFF_CTRL)
            r = {1'b1, 4'h0, ctrl_q};
        if (a == `BCC_OFF_TICK)
            r = {1'b1, tick_reg_q};
        if (a == `BCC_OFF_ALMCTL)
            r = {1'b1, alm_ctl_q};
        for (int k = 0; k < BCC_NALARM; k++)
            if (a == `BCC_OFF_ALM_BASE + 8'(k) * `BCC_WORD_BYTES)
                r = {1'b1, alm_q[k]};
        for (int k = 0; k < BCC_NFIELDS; k++)
            if (a == `BCC_OFF_CAL_BASE + 8'(k) * `BCC_WORD_BYTES)
                r = {1'b1, cal_q[k]};
        return r;
    endfunction
    // mux reads register state, so it must follow every register change
    logic [8:0] rd_sel;
    always_comb rd_sel = rd_mux(araddr);
    logic rvalid_q;
    logic [7:0] rbyte_q;
    bcc_resp_type rresp_q;
    assign arready = ~rvalid_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = {24'h000000, rbyte_q};
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rbyte_q <= '0;
            rresp_q <= `BCC_RESP_OKAY;
        end
        else if (ce)
        begin
            if (arvalid && arready)
            begin
                rvalid_q <= 1'b1;
                // isolated while power is off: reads see zero
                rbyte_q <= powered_off ? 8'h00 : rd_sel[7:0];
                rresp_q <= rd_sel[8] ? `BCC_RESP_OKAY : `BCC_RESP_SLVERR;
            end
            else if (rvalid_q && rready)
                rvalid_q <= 1'b0;
        end
    end
endmodule

// >>> dv/bcc_host_model.sv
// host processor model: axi4-lite master of the calendar clock
`timescale 1ns/1ps
`include "bcc_consts.svh"
module bcc_host_model
    import bcc_pkg::*;
(
    input wire logic aclk,
    output logic [7:0] awaddr = 8'h00,
    output logic awvalid = 1'b0,
    input wire logic awready,
    output logic [31:0] wdata = 32'h00000000,
    output logic [3:0] wstrb = 4'h0,
    output logic wvalid = 1'b0,
    input wire logic wready,
    input wire bcc_resp_type bresp,
    input wire logic bvalid,
    output logic bready = 1'b0,
    output logic [7:0] araddr = 8'h00,
    output logic arvalid = 1'b0,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire bcc_resp_type rresp,
    input wire logic rvalid,
    output logic rready = 1'b0
);
    // released address and data lines show the inverse, not the last value; wstrb keeps 4'hF
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
        output bcc_resp_type r);
        logic aw_done;
        logic w_done;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (awready && !aw_done)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wready && !w_done)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~{24'h000000, d};
            end
        end
        while (!bvalid)
            @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
        output bcc_resp_type r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
            @(posedge aclk);
        while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        do
            @(posedge aclk);
        while (!rvalid);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
    endtask
    // year down to seconds, again if seconds read zero
    task automatic rd_time(output bcc_bcd_type t [BCC_NFIELDS]);
        bcc_resp_type r;
        for (int p = 0; p < 2; p++)
        begin
            for (int f = BCC_NFIELDS - 1; f >= 0; f--)
                rd(`BCC_OFF_CAL_BASE + 8'(4 * f), t[f], r);
            if (t[BCC_F_SEC] !== 8'h00)
                break;
        end
    endtask
endmodule

// >>> dv/bcc_top_assertions.sv
// port assertions of the calendar clock top
`timescale 1ns/1ps
module bcc_top_assertions
    import bcc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic main_power_off,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire bcc_resp_type bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire bcc_resp_type rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic alarm_irq,
    input wire logic tick_irq,
    input wire logic power_wake_request
);
    logic [2:0] off_run_q;
    logic [2:0] on_run_q;
    logic [2:0] off_run_d;
    logic [2:0] on_run_d;
    // cycles the power pin has held its level, saturating
    assign off_run_d = !main_power_off ? 3'h0 :
        (off_run_q == 3'h7 ? 3'h7 : off_run_q + 3'h1);
    assign on_run_d = main_power_off ? 3'h0 :
        (on_run_q == 3'h7 ? 3'h7 : on_run_q + 3'h1);
    always_ff @(posedge aclk)
    begin
        off_run_q <= aresetn ? off_run_d : 3'h0;
        on_run_q <= aresetn ? on_run_d : 3'h0;
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_wake_needs_alarm: assert property (
        power_wake_request |-> alarm_irq)
        else $error("wake request without alarm interrupt");
    a_wake_when_off: assert property (
        alarm_irq && off_run_q == 3'h7 |-> power_wake_request)
        else $error("alarm with power off gave no wake request");
    a_no_wake_on: assert property (
        alarm_irq && on_run_q == 3'h7 |-> !power_wake_request)
        else $error("wake request with main power on");
    a_alarm_spacing: assert property (
        alarm_irq |=> !alarm_irq [*8])
        else $error("alarm pulses too close");
    a_tick_spacing: assert property (
        tick_irq |=> !tick_irq [*8])
        else $error("tick pulses too close");
    a_byte_wide: assert property (
        rvalid |-> rdata[31:8] == 24'h000000)
        else $error("read data wider than a byte");
    a_isolated_read: assert property (
        arvalid && arready && off_run_q == 3'h7
        |=> rdata == 32'h00000000 && rresp == 2'h0)
        else $error("bus not isolated with power off");
    a_read_answer: assert property (
        arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_write_answer: assert property (
        awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write answer late");
    a_bresp_hold: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
endmodule
bind bcc_top bcc_top_assertions u_chk (.*);

// >>> dv/tb_top.sv
// self-checking bench of the bcd calendar clock
`timescale 1ns/1ps
`include "bcc_consts.svh"
module tb_top;
    import bcc_pkg::*;
    localparam logic [7:0] REG_ADDR [16] = '{8'h40, 8'h44, 8'h50,
        8'h54, 8'h58, 8'h5C, 8'h60, 8'h64, 8'h68,
        8'h70, 8'h74, 8'h78, 8'h7C, 8'h80, 8'h84, 8'h88};
    localparam logic [7:0] REG_RST [16] = '{8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    localparam logic [7:0] SET_VAL [7] = '{8'h59, 8'h59, 8'h23,
        8'h28, 8'h07, 8'h02, 8'h00};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic xtal_clk = 1'b0;
    logic main_power_off = 1'b0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic alarm_irq, tick_irq, power_wake_request;
    bcc_resp_type bresp, rresp;
    int errors = 0;
    int compares = 0;
    int tick_seen = 0;
    logic tick_watch = 1'b0;
    integer seed = 32'hDB84E5B4;
    always #25 aclk = ~aclk;
    // crystal scaled to half the bus clock
    always @(posedge aclk)
        xtal_clk <= ~xtal_clk;
    always @(posedge aclk)
        if (tick_watch && tick_irq)
            tick_seen++;
    bcc_top uut (.ce(1'b1), .*);
    bcc_host_model host (.*);
    function automatic logic [7:0] alm_mask(input int i);
        case (i)
            0, 1: return 8'h7F;
            2, 3: return 8'h3F;
            4: return 8'h1F;
            default: return 8'hFF;
        endcase
    endfunction
    function automatic logic [7:0] next_date(input logic [7:0] d,
        input logic [7:0] m, input logic [7:0] y);
        logic [7:0] last;
        last = ((y[7:4] * 10 + y[3:0]) % 4 == 0) ? 8'h29 : 8'h28;
        if (m != 8'h02)
            last = (m == 8'h04 || m == 8'h06 || m == 8'h09 ||
                m == 8'h11) ? 8'h30 : 8'h31;
        if (d == last)
            return 8'h01;
        return (d[3:0] == 4'h9) ? {d[7:4] + 4'h1, 4'h0} : d + 8'h01;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bcc_resp_type r;
        host.rd(a, d, r);
        chk("read response", 32'(`BCC_RESP_OKAY), 32'(r));
        chk($sformatf("register %h", a), 32'(exp), 32'(d));
    endtask
    task automatic wchk(input logic [7:0] a, input logic [7:0] v);
        bcc_resp_type r;
        host.wr(a, v, r);
        chk("write response", 32'(`BCC_RESP_OKAY), 32'(r));
    endtask
    task automatic complete_run;
        $display("counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (95000) @(posedge aclk);
        errors++;
        $display("[FAIL] watchdog expected end seen timeout");
        complete_run;
    end
    initial
    begin
        logic [7:0] d;
        logic [7:0] v;
        logic [6:0] n;
        bcc_resp_type r;
        bcc_bcd_type t [BCC_NFIELDS];
        bcc_bcd_type e [BCC_NFIELDS];
        int c;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 16; i++)
            rchk(REG_ADDR[i], REG_RST[i]);
        $display("test reset_values done");
        host.wr(8'hFC, 8'h55, r);
        chk("unmapped write", 32'(`BCC_RESP_SLVERR), 32'(r));
        host.rd(8'hFC, d, r);
        chk("unmapped read", 32'(`BCC_RESP_SLVERR), 32'(r));
        wchk(`BCC_OFF_CAL_BASE, 8'h12);
        rchk(`BCC_OFF_CAL_BASE, 8'h00);
        $display("test refusals done");
        for (int i = 0; i < BCC_NALARM; i++)
        begin
            v = 8'($random(seed));
            wchk(`BCC_OFF_ALM_BASE + 8'(4 * i), v);
            rchk(`BCC_OFF_ALM_BASE + 8'(4 * i), v & alm_mask(i));
        end
        wchk(`BCC_OFF_ALMCTL, 8'hFF);
        rchk(`BCC_OFF_ALMCTL, 8'h7F);
        $display("test alarm_fields done");
        n = 7'h01 + 7'($random(seed) & 3);
        wchk(`BCC_OFF_TICK, {1'b1, n});
        do
            @(posedge aclk);
        while (!tick_irq);
        c = 0;
        do
        begin
            @(posedge aclk);
            c++;
        end
        while (!tick_irq);
        chk("tick period", 32'((n + 1) * 512), 32'(c));
        wchk(`BCC_OFF_TICK, {1'b0, n});
        repeat (4) @(posedge aclk);
        tick_watch = 1'b1;
        $display("test tick done");
        wchk(`BCC_OFF_CTRL, 8'h01);
        for (int i = 0; i < BCC_NFIELDS; i++)
        begin
            wchk(`BCC_OFF_CAL_BASE + 8'(4 * i), SET_VAL[i]);
            rchk(`BCC_OFF_CAL_BASE + 8'(4 * i), SET_VAL[i]);
        end
        wchk(`BCC_OFF_ALM_BASE, 8'h00);
        wchk(`BCC_OFF_ALMCTL, 8'h41);
        wchk(`BCC_OFF_CTRL, 8'h09);
        wchk(`BCC_OFF_CTRL, 8'h01);
        main_power_off <= 1'b1;
        repeat (8) @(posedge aclk);
        rchk(`BCC_OFF_CAL_BASE, 8'h00);
        wchk(`BCC_OFF_CTRL, 8'h00);
        do
            @(posedge aclk);
        while (!alarm_irq);
        chk("wake with alarm", 32'h1, 32'(power_wake_request));
        main_power_off <= 1'b0;
        repeat (8) @(posedge aclk);
        rchk(`BCC_OFF_CTRL, 8'h01);
        e = '{8'h00, 8'h00, 8'h00,
            next_date(SET_VAL[3], SET_VAL[5], SET_VAL[6]),
            8'h01, SET_VAL[5], SET_VAL[6]};
        host.rd_time(t);
        for (int i = 0; i < BCC_NFIELDS; i++)
            chk($sformatf("field %0d", i), 32'(e[i]), 32'(t[i]));
        chk("ticks while disabled", 32'h0, 32'(tick_seen));
        $display("test rollover_alarm done");
        complete_run;
    end
endmodule
